// ==== rtl/timer8_event_divider.sv ====
// Contract
// - Timer mode counts ticks, match clears, interrupts
// - Tick source selectable, slow keeps low tap
// - Compare value takes effect right after write
// - Event mode counts falling edges, match clears
// - Divider match toggles flip-flop, clears counter
// - Divider interrupt coincides with toggle
// - Divider pin is inverse of flip-flop
// - Flip-flop loaded from init bit, reset 0
// - Stopped divider holds level, init write changes
// - Control bit 3 is run control
// - Control bit 7 holds flip-flop init value
// - Mode 000 timer/event, 001 divider
// - Run bit 0 stops and clears counter
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`include "timer8_consts.svh"

module timer8_event_divider #(
  parameter int FS_DIV = `FS_DIV_DEFAULT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        event_in_pin,
  output logic             divider_out_pin,
  output logic             channel_match_irq,
  output timer8_pkg::byte_t count_value
);
  import timer8_pkg::*;

  // ************************************************
  // Declarations
  // ************************************************
  logic                  aw_held_q, aw_held_d;
  logic [3:0]            awaddr_q, awaddr_d;
  logic                  w_held_q, w_held_d;
  logic [31:0]           wdata_q, wdata_d;
  logic                  wlane_q, wlane_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  rvalid_q, rvalid_d;
  logic [1:0]            rresp_q, rresp_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  do_write;
  logic                  wr_ctl;
  logic                  wr_cmp;
  logic                  wr_cfg;
  byte_t                 ctl_q, ctl_d;
  byte_t                 cmp_q, cmp_d;
  logic [1:0]            cfg_q, cfg_d;
  byte_t                 cnt_q, cnt_d;
  logic                  ff_q, ff_d;
  logic                  irq_q, irq_d;
  logic                  ev_meta_q, ev_sync_q, ev_last_q;
  logic                  ev_fall;
  logic                  tick;
  logic                  run;
  logic [2:0]            mode;
  clk_sel_t              sel;
  count_src_e            src;
  logic                  advance;
  logic                  match;
  byte_t                 cnt_inc;

  // Address is mapped
  function automatic logic addr_ok(input logic [3:0] a);
    return (a == `OFS_CONTROL) || (a == `OFS_COMPARE) || (a == `OFS_CONFIG) || (a == `OFS_STATUS);
  endfunction

  // ************************************************
  // Write channel
  // ************************************************
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign do_write      = aw_held_q && w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Hold address and data until both arrive, then answer
  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wlane_d  = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_ok(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
      w_held_q  <= 1'b0;
      wdata_q   <= '0;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
      w_held_q  <= w_held_d;
      wdata_q   <= wdata_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ************************************************
  // Read channel
  // ************************************************
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Register read mux, upper bits read zero except status bit 8, which reads the flip-flop
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = '0;
      if (s_axi_araddr == `OFS_CONTROL) begin
        rdata_d[7:0] = ctl_q;
      end else if (s_axi_araddr == `OFS_COMPARE) begin
        rdata_d[7:0] = cmp_q;
      end else if (s_axi_araddr == `OFS_CONFIG) begin
        rdata_d[1:0] = cfg_q;
      end else if (s_axi_araddr == `OFS_STATUS) begin
        rdata_d[7:0]        = cnt_q;
        rdata_d[`STS_FF]    = ff_q;
      end else begin
        rresp_d = `RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ************************************************
  // Software registers
  // ************************************************
  assign wr_ctl = do_write && wlane_q && (awaddr_q == `OFS_CONTROL);
  assign wr_cmp = do_write && wlane_q && (awaddr_q == `OFS_COMPARE);
  assign wr_cfg = do_write && wlane_q && (awaddr_q == `OFS_CONFIG);

  // Compare is a plain register, no shadow copy
  always_comb begin
    ctl_d = wr_ctl ? wdata_q[7:0] : ctl_q;
    cmp_d = wr_cmp ? wdata_q[7:0] : cmp_q;
    cfg_d = wr_cfg ? wdata_q[1:0] : cfg_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= `CTL_RESET;
      cmp_q <= `CMP_RESET;
      cfg_q <= `CFG_RESET;
    end else begin
      ctl_q <= ctl_d;
      cmp_q <= cmp_d;
      cfg_q <= cfg_d;
    end
  end

  // ************************************************
  // Event pin synchroniser and edge detect
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_meta_q <= 1'b1;
      ev_sync_q <= 1'b1;
      ev_last_q <= 1'b1;
    end else begin
      ev_meta_q <= event_in_pin;
      ev_sync_q <= ev_meta_q;
      ev_last_q <= ev_sync_q;
    end
  end

  assign ev_fall = ev_last_q && !ev_sync_q;

  // ************************************************
  // Prescaler
  // ************************************************
  timer8_prescaler #(
    .FS_DIV (FS_DIV)
  ) u_prescaler (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tap_select (cfg_q[`CFG_TAP]),
    .slow_mode  (cfg_q[`CFG_SLOW]),
    .clk_sel    (sel),
    .tick       (tick)
  );

  // ************************************************
  // Counter, compare and toggle flip-flop
  // ************************************************
  assign run  = ctl_q[`CTL_RUN];
  assign mode = ctl_q[`CTL_MODE_HI:`CTL_MODE_LO];
  assign sel  = ctl_q[`CTL_SEL_HI:`CTL_SEL_LO];

  // Pick what advances the counter in each mode
  always_comb begin
    src = SRC_NONE;
    if (run && mode == `MODE_TIMER_EVENT) begin
      src = (sel == `SEL_EVENT) ? SRC_EVENT : SRC_TICK;
    end else if (run && mode == `MODE_DIVIDER && sel != `SEL_EVENT) begin
      src = SRC_TICK;
    end
  end

  assign advance = (src == SRC_TICK && tick) || (src == SRC_EVENT && ev_fall);
  assign cnt_inc = cnt_q + 8'h01;
  assign match   = advance && (cnt_inc == cmp_q);

  // Count, clear on match or stop, toggle in divider mode
  always_comb begin
    cnt_d = cnt_q;
    ff_d  = ff_q;
    irq_d = 1'b0;
    if (!run) begin
      cnt_d = 8'h00;
    end else if (match) begin
      cnt_d = 8'h00;
      irq_d = 1'b1;
      if (mode == `MODE_DIVIDER) begin
        ff_d = !ff_q;
      end
    end else if (advance) begin
      cnt_d = cnt_inc;
    end
    // Load only while stopped, so a stop write keeps the level
    if (wr_ctl && !run) begin
      ff_d = wdata_q[`CTL_FF_INIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      ff_q  <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ff_q  <= ff_d;
      irq_q <= irq_d;
    end
  end

  assign divider_out_pin   = !ff_q;
  assign channel_match_irq = irq_q;
  assign count_value       = cnt_q;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_match;
    match && !wr_ctl;
  endsequence

  sequence s_ctl_write;
    wr_ctl;
  endsequence

  chk_match_clears: assert property (s_match |=> cnt_q == 8'h00 && irq_q)
    else $error("match did not clear and interrupt");
  chk_div_toggle: assert property (s_match ##0 mode == `MODE_DIVIDER |=> ff_q != $past(ff_q))
    else $error("divider match did not toggle");
  chk_irq_toggle: assert property (irq_q && $past(mode) == `MODE_DIVIDER && !$past(wr_ctl)
    |-> ff_q != $past(ff_q) && cnt_q == 8'h00)
    else $error("divider interrupt not with toggle");
  chk_cmp_immediate: assert property (wr_cmp |=> cmp_q == $past(wdata_q[7:0]))
    else $error("compare write not applied");
  chk_event_count: assert property (src == SRC_EVENT && ev_fall && !match && !wr_ctl
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("event edge not counted");
  chk_event_once: assert property (src == SRC_EVENT && !ev_fall && !wr_ctl |=> $stable(cnt_q))
    else $error("counted without falling edge");
  chk_stop_clears: assert property (!run |=> cnt_q == 8'h00)
    else $error("stopped counter not cleared");
  chk_stop_holds: assert property (!run && !wr_ctl |=> $stable(ff_q))
    else $error("stopped output changed");
  chk_stop_write: assert property (wr_ctl && run && !match |=> $stable(ff_q))
    else $error("stop write moved the output");
  chk_ff_load: assert property (s_ctl_write ##0 !run |=> ff_q == $past(wdata_q[`CTL_FF_INIT]))
    else $error("init bit not loaded");
  chk_run_start: assert property (s_ctl_write ##0 wdata_q[`CTL_RUN] |=> run)
    else $error("run bit did not start");
  chk_reset_stopped: assert property (disable iff (1'b0) $past(!aresetn) |-> !run && cnt_q == 8'h00 && !ff_q)
    else $error("reset left channel running");

endmodule

// ==== include/timer8_consts.svh ====
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// ************************************************
// Register byte offsets
// ************************************************
`define OFS_CONTROL      4'h0
`define OFS_COMPARE      4'h4
`define OFS_CONFIG       4'h8
`define OFS_STATUS       4'hC
`define ADDR_LSB         2
`define ADDR_BITS        4

// ************************************************
// Control, config and status register fields
// ************************************************
`define CTL_FF_INIT      7
`define CTL_SEL_HI       6
`define CTL_SEL_LO       4
`define CTL_RUN          3
`define CTL_MODE_HI      2
`define CTL_MODE_LO      0
`define CFG_TAP          0
`define CFG_SLOW         1
`define STS_FF           8

// ************************************************
// Field codes and reset values
// ************************************************
`define MODE_TIMER_EVENT 3'h0
`define MODE_DIVIDER     3'h1
`define SEL_SLOW_TAP     3'h0
`define SEL_FC7          3'h1
`define SEL_FC5          3'h2
`define SEL_FC3          3'h3
`define SEL_EVENT        3'h6
`define CTL_RESET        8'h00
`define CMP_RESET        8'hFF
`define CFG_RESET        2'h0

// ************************************************
// Prescaler taps and bus answers
// ************************************************
`define TAP_FC11         11
`define TAP_FC7          7
`define TAP_FC5          5
`define TAP_FC3          3
`define FS_TAP_WIDTH     3
`define FS_DIV_DEFAULT   305
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== include/timer8_pkg.sv ====
package timer8_pkg;

  // Counter, compare and control width
  typedef logic [7:0] byte_t;

  // Clock select field
  typedef logic [2:0] clk_sel_t;

  // What advances the counter
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_TICK,
    SRC_EVENT
  } count_src_e;

endpackage

// ==== rtl/timer8_prescaler.sv ====
`include "timer8_consts.svh"

module timer8_prescaler #(
  parameter int FS_DIV = `FS_DIV_DEFAULT
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              tap_select,
  input  wire logic              slow_mode,
  input  wire timer8_pkg::clk_sel_t clk_sel,
  output logic                   tick
);
  import timer8_pkg::*;

  localparam int FSW = $clog2(FS_DIV);

  logic [`TAP_FC11-1:0]     div_q;
  logic [`TAP_FC11-1:0]     div_d;
  logic [FSW-1:0]           fs_q;
  logic [FSW-1:0]           fs_d;
  logic [`FS_TAP_WIDTH-1:0] fs8_q;
  logic [`FS_TAP_WIDTH-1:0] fs8_d;
  logic                     fs_pulse;
  logic                     fs8_tick;

  // True once every 2^n clocks
  function automatic logic tap_hit(input logic [`TAP_FC11-1:0] v, input int n);
    logic [`TAP_FC11-1:0] m;
    m = (`TAP_FC11'(1) << n) - `TAP_FC11'(1);
    return (v & m) == m;
  endfunction

  // ************************************************
  // Dividers from the system clock
  // ************************************************
  always_comb begin
    div_d    = div_q + `TAP_FC11'(1);
    fs_pulse = (fs_q == FSW'(FS_DIV - 1));
    fs_d     = fs_pulse ? '0 : fs_q + FSW'(1);
    fs8_d    = fs_pulse ? fs8_q + `FS_TAP_WIDTH'(1) : fs8_q;
    fs8_tick = fs_pulse && (&fs8_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      fs_q  <= '0;
      fs8_q <= '0;
    end else begin
      div_q <= div_d;
      fs_q  <= fs_d;
      fs8_q <= fs8_d;
    end
  end

  // Source clock select, slow mode keeps only the low tap
  always_comb begin
    tick = 1'b0;
    if (slow_mode) begin
      tick = (clk_sel == `SEL_SLOW_TAP) && fs8_tick;
    end else if (clk_sel == `SEL_SLOW_TAP) begin
      tick = tap_select ? fs8_tick : tap_hit(div_q, `TAP_FC11);
    end else if (clk_sel == `SEL_FC7) begin
      tick = tap_hit(div_q, `TAP_FC7);
    end else if (clk_sel == `SEL_FC5) begin
      tick = tap_hit(div_q, `TAP_FC5);
    end else if (clk_sel == `SEL_FC3) begin
      tick = tap_hit(div_q, `TAP_FC3);
    end
  end

  chk_slow_no_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    slow_mode && (clk_sel != `SEL_SLOW_TAP) |-> !tick)
    else $error("fast tap ticked in slow mode");

endmodule

// ==== testbench/timer8_pin_model.sv ====
module timer8_pin_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [3:0] half,
  input  wire logic [7:0] num,
  output logic            event_in_pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // External event source
  // ****************************************
  logic [3:0] ph;
  logic [8:0] left;
  logic [3:0] hl;

  // Each level lasts at least eight clocks, at most fc/16 events
  assign hl = (half < 4'h8) ? 4'h8 : half;

  // Idle high, then num falling edges at the chosen rate
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_in_pin <= 1'b1;
      busy         <= 1'b0;
      ph           <= 4'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      left <= {num, 1'b0};
      ph   <= 4'h0;
    end else if (busy) begin
      if (ph == hl - 4'h1) begin
        ph           <= 4'h0;
        event_in_pin <= ~event_in_pin;
        left         <= left - 9'h1;
        if (left == 9'h1) busy <= 1'b0;
      end else begin
        ph <= ph + 4'h1;
      end
    end
  end
endmodule

// ==== testbench/timer8_event_divider_test.sv ====
`include "timer8_consts.svh"

module timer8_event_divider_test;
  timeunit 1ns;
  timeprecision 1ns;
  import timer8_pkg::*;

  // ****************************************
  // Signals and bookkeeping
  // ****************************************
  localparam int FS_DIV = 4;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb, half;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        event_in_pin, divider_out_pin, irq, go, busy, div_chk, pin_prev;
  logic [7:0]  num;
  byte_t       count_value;
  int          err_count, checks, cyc, last_irq;
  logic [31:0] lfsr;
  logic [31:0] rd_q[$];
  logic [1:0]  resp_q[$];
  logic [1:0]  rr_q[$];
  logic [15:0] per_q[$];
  logic [2:0]  t_sel [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0};
  logic [1:0]  t_cfg [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  int          t_tick [6] = '{2048, 128, 32, 8, FS_DIV * 8, FS_DIV * 8};

  timer8_event_divider #(.FS_DIV(FS_DIV)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in_pin(event_in_pin),
    .divider_out_pin(divider_out_pin), .channel_match_irq(irq), .count_value(count_value)
  );

  timer8_pin_model pins (
    .aclk(aclk), .aresetn(aresetn), .go(go), .half(half), .num(num),
    .event_in_pin(event_in_pin), .busy(busy)
  );

  // Clock generator
  always #50 aclk = ~aclk;

  // ****************************************
  // Compare, report and bus tasks
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report(input logic [31:0] got, input logic [31:0] exp, input logic ok);
    checks++;
    if (!ok) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp, got === exp);
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    report({30'h0, got}, {30'h0, exp}, got === exp);
  endtask

  task automatic cmp_period(input logic [15:0] got, input logic [15:0] exp);
    report({16'h0, got}, {16'h0, exp}, got === exp);
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    report({31'h0, got}, {31'h0, exp}, got === exp);
  endtask

  task automatic test_done();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout();
    report(32'h0, 32'h1, 1'b0);
    test_done();
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    logic s_aw, s_w, s_b;
    n = 0;
    s_b = 1'b0;
    resp_q.push_back(r);
    lfsr = lfsr_next(lfsr);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {lfsr[23:0], d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!s_b) begin
      @(negedge aclk);
      s_aw = awvalid && awready;
      s_w = wvalid && wready;
      s_b = bvalid;
      @(posedge aclk);
      if (s_aw) awvalid <= 1'b0;
      if (s_w) wvalid <= 1'b0;
      if (s_b) bready <= 1'b0;
      n++;
      if (n > 200) timeout();
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp);
    int n;
    logic s_ar, s_r;
    n = 0;
    s_r = 1'b0;
    rd_q.push_back(exp);
    rr_q.push_back((a[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!s_r) begin
      @(negedge aclk);
      s_ar = arvalid && arready;
      s_r = rvalid;
      @(posedge aclk);
      if (s_ar) arvalid <= 1'b0;
      if (s_r) rready <= 1'b0;
      n++;
      if (n > 200) timeout();
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 12000) timeout();
    end while (!irq);
    @(posedge aclk);
  endtask

  // Result watcher: oldest note against each answer
  always @(negedge aclk) begin
    cyc++;
    if (bvalid && bready) cmp_resp(bresp, resp_q.pop_front());
    if (rvalid && rready) begin
      cmp_word(rdata, rd_q.pop_front());
      cmp_resp(rresp, rr_q.pop_front());
    end
    if (irq) begin
      if (per_q.size() > 0) cmp_period(16'(cyc - last_irq), per_q.pop_front());
      if (div_chk) cmp_bit(divider_out_pin, ~pin_prev);
      last_irq = cyc;
    end
    pin_prev = divider_out_pin;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] cv;
    int n;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, div_chk} = '0;
    {awaddr, araddr, wstrb, wdata, num} = '0;
    half = 4'h8;
    lfsr = 32'h1B3C;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_bit(divider_out_pin, 1'b1);
    axi_rd(`OFS_CONTROL, 32'h0);
    axi_rd(`OFS_COMPARE, 32'hFF);
    axi_rd(`OFS_CONFIG, 32'h0);
    axi_rd(`OFS_STATUS, 32'h0);
    axi_wr(`OFS_STATUS, 8'hFF, `RESP_OKAY);
    axi_wr(4'h2, 8'hFF, `RESP_SLVERR);
    axi_rd(4'h6, 32'h0);
    axi_rd(`OFS_STATUS, 32'h0);
    // Every internal tap with a random compare value
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      cv = {14'h0, lfsr[1:0]} + 16'h2;
      axi_wr(`OFS_CONFIG, {6'h0, t_cfg[i]}, `RESP_OKAY);
      axi_wr(`OFS_COMPARE, cv[7:0], `RESP_OKAY);
      axi_wr(`OFS_CONTROL, {1'b0, t_sel[i], 4'h0}, `RESP_OKAY);
      axi_rd(`OFS_STATUS, 32'h0);
      axi_wr(`OFS_CONTROL, {1'b0, t_sel[i], 4'h8}, `RESP_OKAY);
      wait_irq();
      per_q.push_back(cv * 16'(t_tick[i]));
      wait_irq();
      axi_wr(`OFS_CONTROL, 8'h00, `RESP_OKAY);
    end
    // Slow mode leaves only the low tap
    axi_wr(`OFS_CONFIG, 8'h02, `RESP_OKAY);
    axi_wr(`OFS_CONTROL, 8'h38, `RESP_OKAY);
    repeat (100) @(posedge aclk);
    axi_rd(`OFS_STATUS, 32'h0);
    axi_wr(`OFS_CONTROL, 8'h00, `RESP_OKAY);
    axi_wr(`OFS_CONFIG, 8'h00, `RESP_OKAY);
    // Event counting at the fastest legal rate
    axi_wr(`OFS_COMPARE, 8'h04, `RESP_OKAY);
    axi_wr(`OFS_CONTROL, 8'h68, `RESP_OKAY);
    num <= 8'd10;
    go  <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wait_irq();
    per_q.push_back(16'd64);
    wait_irq();
    n = 0;
    while (busy) begin
      @(posedge aclk);
      n++;
      if (n > 500) timeout();
    end
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    cmp_word({24'h0, count_value}, 32'h2);
    axi_rd(`OFS_STATUS, 32'h2);
    axi_wr(`OFS_CONTROL, 8'h60, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h0);
    // Divider toggles, stop holds the level
    axi_wr(`OFS_COMPARE, 8'h02, `RESP_OKAY);
    div_chk = 1'b1;
    axi_wr(`OFS_CONTROL, 8'h39, `RESP_OKAY);
    wait_irq();
    per_q.push_back(16'd16);
    wait_irq();
    wait_irq();
    div_chk = 1'b0;
    axi_wr(`OFS_CONTROL, 8'h31, `RESP_OKAY);
    @(negedge aclk);
    cmp_bit(divider_out_pin, 1'b0);
    axi_rd(`OFS_STATUS, 32'h100);
    axi_wr(`OFS_CONTROL, 8'h01, `RESP_OKAY);
    @(negedge aclk);
    cmp_bit(divider_out_pin, 1'b1);
    axi_wr(`OFS_CONTROL, 8'h81, `RESP_OKAY);
    @(negedge aclk);
    cmp_bit(divider_out_pin, 1'b0);
    axi_rd(`OFS_STATUS, 32'h100);
    test_done();
  end
endmodule
